// File: closure_pkg.sv
package closure_pkg;
  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int channel_count = 40;
  localparam int count_width = 32;
  localparam int chan_width = 6;
  localparam int interval_width = 11;
  localparam logic [interval_width-1:0] interval_default = 11'h00f;
  localparam logic [interval_width-1:0] interval_min = 11'h001;
  localparam logic [interval_width-1:0] interval_max = 11'h5a0;
  localparam int clock_hz = 40000000;
  localparam int minute_seconds = 60;
  localparam longint minute_cycles = longint'(clock_hz) * minute_seconds;
  localparam logic [count_width-1:0] count_zero = 32'h00000000;
  localparam logic [count_width-1:0] count_one = 32'h00000001;
  localparam logic [interval_width-1:0] minute_one = 11'h001;
  localparam logic [interval_width-1:0] minute_zero = 11'h000;

  typedef enum logic [1:0] {
    idle_type_s,
    load_type_s,
    store_type_s
  } nv_state_type;
endpackage

// File: nv_store_model.sv
module nv_store_model
  import closure_pkg::*;
(
  // clock
  input wire logic clock,
  // store port of the counter
  input wire logic nv_write,
  input wire logic nv_read,
  input wire logic [closure_pkg::chan_width-1:0] nv_channel,
  input wire logic [closure_pkg::count_width-1:0] nv_write_data,
  output logic [closure_pkg::count_width-1:0] nv_read_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [count_width-1:0] mem [channel_count];
  initial begin
    for (int i = 0; i < channel_count; i++) mem[i] = 32'h00000100 + i;
  end
  // inverted word outside a load, so a stray sample never looks like a count
  assign nv_read_data = nv_read ? mem[nv_channel] : ~mem[nv_channel];
  always @(posedge clock) if (nv_write) mem[nv_channel] <= nv_write_data;
endmodule

// File: relay_closure_counter.sv
// Functional notes
// - count only on open-to-closed transitions
// - a held close adds one only
// - any closure source updates volatile count; code ignores closures on every channel during the power-up load
// - copy counts to nonvolatile each interval; 15
// - accept interval 1 to 1440 only
// - count query also triggers nonvolatile copy
// - zero listed channels only in calibration
// - read or zero only via remote
// - interval query returns programmed minutes
// - count query returns each listed count
module relay_closure_counter
  import closure_pkg::*;
#(
  parameter longint minute_ticks = minute_cycles
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // relay states, one bit per channel, high is closed
  input wire logic [closure_pkg::channel_count-1:0] relay_closed,
  // remote command port (the only path to counts)
  input wire logic calibration_mode,
  input wire logic count_query,
  input wire logic [closure_pkg::chan_width-1:0] query_channel,
  input wire logic zero_closure_tally,
  input wire logic [closure_pkg::chan_width-1:0] zero_channel,
  input wire logic interval_write,
  input wire logic [closure_pkg::interval_width-1:0] interval_value,
  output logic interval_rejected,
  output logic [closure_pkg::interval_width-1:0] interval_minutes,
  output logic count_valid,
  output logic [closure_pkg::count_width-1:0] count_data,
  // nonvolatile store port
  output logic nv_write,
  output logic nv_read,
  output logic [closure_pkg::chan_width-1:0] nv_channel,
  output logic [closure_pkg::count_width-1:0] nv_write_data,
  input wire logic [closure_pkg::count_width-1:0] nv_read_data,
  output logic nv_busy
);
  import closure_pkg::*;

  // ----------------------------------------
  // input synchroniser for relay states
  // ----------------------------------------
  logic [channel_count-1:0] relay_s1, relay_s2, relay_s3, relay_state;
  wire [channel_count-1:0] agree = ~(relay_s2 ^ relay_s3);
  wire [channel_count-1:0] next_relay_state = (agree & relay_s3) | (~agree & relay_state);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      relay_s1 <= '0;
      relay_s2 <= '0;
      relay_s3 <= '0;
      relay_state <= '0;
    end else begin
      relay_s1 <= relay_closed;
      relay_s2 <= relay_s1;
      relay_s3 <= relay_s2;
      relay_state <= next_relay_state;
    end
  end
  // a held close keeps the state high, so only the rising edge counts
  wire [channel_count-1:0] closure_edge = next_relay_state & ~relay_state;

  // ----------------------------------------
  // interval register and minute timer
  // ----------------------------------------
  wire interval_ok = (interval_value >= interval_min) && (interval_value <= interval_max);
  logic [63:0] tick_count;
  logic [interval_width-1:0] minutes_elapsed;
  wire minute_tick = (tick_count == 64'(minute_ticks - 1));
  wire interval_due = minute_tick && (minutes_elapsed + minute_one >= interval_minutes);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      interval_minutes <= interval_default;
      interval_rejected <= 1'b0;
      tick_count <= '0;
      minutes_elapsed <= minute_zero;
    end else begin
      interval_rejected <= interval_write && !interval_ok;
      if (interval_write && interval_ok) begin
        interval_minutes <= interval_value;
        minutes_elapsed <= minute_zero;
      end else if (interval_due) begin
        minutes_elapsed <= minute_zero;
      end else if (minute_tick) begin
        minutes_elapsed <= minutes_elapsed + minute_one;
      end
      tick_count <= minute_tick ? '0 : tick_count + 64'd1;
    end
  end

  // ----------------------------------------
  // volatile counts
  // ----------------------------------------
  logic [count_width-1:0] counts [channel_count];
  nv_state_type state;
  logic [chan_width-1:0] walk;
  logic store_pending;
  wire walk_last = (walk == chan_width'(channel_count - 1));
  wire zero_ok = zero_closure_tally && calibration_mode;
  wire loading = (state == load_type_s);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < channel_count; i++) begin
        counts[i] <= count_zero;
      end
    end else begin
      for (int i = 0; i < channel_count; i++) begin
        if (loading && walk == chan_width'(i)) begin
          counts[i] <= nv_read_data;
        end else if (zero_ok && zero_channel == chan_width'(i)) begin
          counts[i] <= count_zero;
        end else if (!loading && closure_edge[i]) begin
          counts[i] <= counts[i] + count_one;
        end
      end
    end
  end

  // query answer, from the remote port only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_valid <= 1'b0;
      count_data <= count_zero;
    end else begin
      count_valid <= count_query;
      if (count_query) begin
        count_data <= counts[query_channel];
      end
    end
  end

  // ----------------------------------------
  // nonvolatile copy sequencer
  // ----------------------------------------
  // closures made while a copy walks are caught by the next copy; counts
  // not yet copied are lost on power loss, which is the interval trade-off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= load_type_s;
      walk <= '0;
      store_pending <= 1'b0;
    end else begin
      if (interval_due || count_query) begin
        store_pending <= 1'b1;
      end
      unique case (state)
        load_type_s: begin
          walk <= walk_last ? '0 : walk + 1'b1;
          if (walk_last) begin
            state <= idle_type_s;
          end
        end
        idle_type_s: begin
          if (store_pending) begin
            state <= store_type_s;
            walk <= '0;
            store_pending <= interval_due || count_query;
          end
        end
        store_type_s: begin
          walk <= walk_last ? '0 : walk + 1'b1;
          if (walk_last) begin
            state <= idle_type_s;
          end
        end
      endcase
    end
  end

  assign nv_read = loading;
  assign nv_write = (state == store_type_s);
  assign nv_channel = walk;
  assign nv_write_data = counts[walk];
  assign nv_busy = (state != idle_type_s);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_zero_needs_cal: assert property (@(posedge clock) disable iff (rst)
    zero_closure_tally && !calibration_mode && !closure_edge[zero_channel] && !loading
      |=> counts[$past(zero_channel)] == $past(counts[zero_channel]))
    else $error("count zeroed outside calibration mode");
  a_interval_reject: assert property (@(posedge clock) disable iff (rst)
    interval_write && !interval_ok |=> interval_rejected && $stable(interval_minutes))
    else $error("out of range interval accepted");
  a_interval_accept: assert property (@(posedge clock) disable iff (rst)
    interval_write && interval_ok |=> interval_minutes == $past(interval_value))
    else $error("valid interval not stored");
  a_query_answer: assert property (@(posedge clock) disable iff (rst)
    count_query |=> count_valid)
    else $error("count query not answered");
  a_query_store: assert property (@(posedge clock) disable iff (rst)
    count_query |=> store_pending || nv_write)
    else $error("query did not schedule copy");
  a_single_count: assert property (@(posedge clock) disable iff (rst)
    relay_state[0] && $past(relay_state[0]) && !$past(loading) && !$past(zero_ok)
      |-> counts[0] == $past(counts[0]))
    else $error("held closure counted again");
  a_edge_count: assert property (@(posedge clock) disable iff (rst)
    closure_edge[0] && !loading && !(zero_ok && zero_channel == '0)
      |=> counts[0] == $past(counts[0]) + count_one)
    else $error("closure not counted");
  a_store_walk: assert property (@(posedge clock) disable iff (rst)
    state == idle_type_s ##1 state == store_type_s |-> walk == '0)
    else $error("copy did not start at channel zero");
  // an answer without a remote query would mean a local read path exists
  a_answer_source: assert property (@(posedge clock) disable iff (rst)
    count_valid |-> $past(count_query))
    else $error("count answered without a query");
  a_due_store: assert property (@(posedge clock) disable iff (rst)
    interval_due |=> store_pending || nv_write)
    else $error("elapsed interval did not schedule copy");
  a_zero_applied: assert property (@(posedge clock) disable iff (rst)
    zero_ok && !loading |=> counts[$past(zero_channel)] == count_zero)
    else $error("listed channel not zeroed in calibration");
  a_load_step: assert property (@(posedge clock) disable iff (rst)
    loading && !walk_last |=> walk == $past(walk) + 1'b1)
    else $error("power-up load skipped a channel");
  a_interval_range: assert property (@(posedge clock) disable iff (rst)
    interval_minutes >= interval_min && interval_minutes <= interval_max)
    else $error("interval outside legal range");
endmodule

// File: relay_closure_counter_tb_top.sv
module relay_closure_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import closure_pkg::*;
  logic clock = 0, rst = 1, calibration_mode = 0, count_query = 0, zero_closure_tally = 0, interval_write = 0;
  logic [39:0] relay_closed = '0;
  logic [5:0] query_channel = '0, zero_channel = '0, nv_channel, ch;
  logic [10:0] interval_value = '0, interval_minutes, cur;
  logic interval_rejected, count_valid, nv_write, nv_read, nv_busy, seen;
  logic [31:0] count_data, nv_write_data, nv_read_data;
  logic [31:0] exp_q[$], exp[40];
  logic [15:0] seed = 16'h893f;
  logic [10:0] vals[6] = '{11'h000, 11'h5a1, 11'h7ff, 11'h001, 11'h5a0, 11'h000};
  int failures = 0, compares = 0, cycles = 0;
  relay_closure_counter #(.minute_ticks(20)) dut_u (.clock(clock), .rst(rst), .relay_closed(relay_closed),
    .calibration_mode(calibration_mode), .count_query(count_query), .query_channel(query_channel),
    .zero_closure_tally(zero_closure_tally), .zero_channel(zero_channel), .interval_write(interval_write),
    .interval_value(interval_value), .interval_rejected(interval_rejected), .interval_minutes(interval_minutes),
    .count_valid(count_valid), .count_data(count_data), .nv_write(nv_write), .nv_read(nv_read),
    .nv_channel(nv_channel), .nv_write_data(nv_write_data), .nv_read_data(nv_read_data), .nv_busy(nv_busy));
  nv_store_model nv_u (.clock(clock), .nv_write(nv_write), .nv_read(nv_read), .nv_channel(nv_channel),
    .nv_write_data(nv_write_data), .nv_read_data(nv_read_data));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic tally(input logic ok, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic compare_count(input logic [31:0] e, input logic [31:0] g);
    tally(g === e, e, g);
  endtask
  task automatic compare_interval(input logic [10:0] e, input logic [10:0] g);
    tally(g === e, 32'(e), 32'(g));
  endtask
  task automatic compare_flag(input logic e, input logic g);
    tally(g === e, 32'(e), 32'(g));
  endtask
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge clock) if (count_valid === 1'b1) compare_count(exp_q.pop_front(), count_data);
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict;
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic query(input logic [5:0] c);
    count_query = 1;
    query_channel = c;
    exp_q.push_back(exp[c]);
    @(negedge clock) count_query = 0;
    @(negedge clock);
  endtask
  // a copy request can sit one idle cycle before the walk starts, so look twice
  task automatic wait_idle;
    for (int i = 0; i < 200 && nv_busy !== 1'b0; i++) @(negedge clock);
    @(negedge clock);
    for (int i = 0; i < 200 && nv_busy !== 1'b0; i++) @(negedge clock);
  endtask
  task automatic store_within(input int n);
    seen = 0;
    repeat (n) @(negedge clock) seen |= (nv_write === 1'b1);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clock);
    rst = 0;
    wait_idle;
    compare_interval(11'h00f, interval_minutes);
    for (int i = 0; i < 40; i++) exp[i] = 32'h00000100 + i;
    query(6'h07);
    relay_closed[0] = 1;
    repeat (16) @(negedge clock);
    relay_closed[0] = 0;
    exp[0] += 1;
    query(6'h00);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr_next(seed);
      ch = 6'(seed % 40);
      repeat (2) begin
        relay_closed[ch] = 1;
        repeat (8) @(negedge clock);
        relay_closed[ch] = 0;
        repeat (8) @(negedge clock);
      end
      exp[ch] += 2;
      query(ch);
      store_within(4);
      compare_flag(1'b1, seen);
      wait_idle;
      compare_count(exp[ch], nv_u.mem[ch]);
      for (int cal = 0; cal < 2; cal++) begin
        calibration_mode = cal[0];
        zero_closure_tally = 1;
        zero_channel = ch;
        @(negedge clock) zero_closure_tally = 0;
        if (cal == 1) exp[ch] = 32'h0;
        query(ch);
      end
      calibration_mode = 0;
    end
    cur = 11'h00f;
    seed = lfsr_next(seed);
    vals[5] = 11'(seed % 1440) + 11'h001;
    foreach (vals[i]) begin
      interval_write = 1;
      interval_value = vals[i];
      @(negedge clock) interval_write = 0;
      if (vals[i] != 0 && vals[i] <= 11'h5a0) cur = vals[i];
      compare_flag(vals[i] == 0 || vals[i] > 11'h5a0, interval_rejected);
      compare_interval(cur, interval_minutes);
      @(negedge clock);
    end
    wait_idle;
    store_within(100);
    compare_flag(1'b0, seen);
    interval_write = 1;
    interval_value = 11'h001;
    @(negedge clock) interval_write = 0;
    store_within(25);
    compare_flag(1'b1, seen);
    wait_idle;
    compare_count(32'h0, 32'(exp_q.size()));
    print_verdict;
  end
endmodule
